//--- src/fbst_tap.sv
// boundary-scan test port: tap controller, instruction, boundary, bypass and vendor paths
//
// Notes on behaviour
// - readback limited by option: none, exactly one, or unlimited
// - four test pins only: data in, mode select, test clock, data out
// - reconfiguration pin resets the controller, instruction register and update stage alongside power-up reset
// - three-bit instruction register with eight fixed codes
// - extest: two bits per pad, drive when enabled, else capture pad input
// - sample captures all pads and their enables at once, no disturbance
// - two ring instructions link user scan chains between data in and out
// - configuration write loads configuration serially from data in
// - configuration read shifts configuration memory out after configuration
// - every pad has a cell except config clock, done and test pads
// - chain runs clockwise from top-left pad to top of left edge
// - bypass uses a single flip-flop between data in and data out
// - scan active before and during configuration, afterwards by option
// - no identification register or instruction
// - scan disabled: pins become user io, data out tristate or readback
// - sixteen standard states, changed only on rising test clock edges by mode select, or by reset
// - outputs test reset, select, data-out enable, capture/shift/update strobes
// - capture loads, shift moves bits, update loads decode or pad controls
// - data out pad shared with configuration readback data
// - sample inputs on rising test clock, change data out on falling
// - extest drives pads on falling test clock edge
// - pad mode picks scan data for extest, functional data otherwise
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module fbst_tap #(
  parameter int NPADS = fbst_pkg::NPADS_DEF
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic tck_pin,
  input wire logic tms_pin,
  input wire logic tdi_pin,
  output logic tdo_out,
  output logic tdo_oe,
  input wire logic powerup_reset_in,
  input wire logic reconfigure_pin_n,
  input wire logic config_done,
  input wire logic scan_keep,
  input wire logic [1:0] readback_option,
  input wire logic rd_data_in,
  input wire logic rd_data_oe_in,
  input wire logic [NPADS-1:0] pad_in,
  output logic [NPADS-1:0] pad_out,
  output logic [NPADS-1:0] pad_oe,
  input wire logic [NPADS-1:0] core_out,
  input wire logic [NPADS-1:0] core_oe,
  output logic [NPADS-1:0] core_in,
  output logic [2:0] user_pins,
  input wire logic ring1_so,
  input wire logic ring2_so,
  output logic ring_si,
  output logic ring1_sel,
  output logic ring2_sel,
  output logic ring_capture,
  output logic ring_shift,
  output logic ring_update,
  output logic cfg_wr_bit,
  output logic cfg_wr_stb,
  input wire logic cfg_rd_bit,
  output logic cfg_rd_next,
  output logic test_reset,
  output logic sel_ir,
  output logic tdo_enable,
  output logic capture_dr,
  output logic capture_ir,
  output logic shift_dr,
  output logic shift_ir,
  output logic update_dr,
  output logic update_ir,
  output logic scan_active
);
  import fbst_pkg::*;

  localparam int NB = NPADS * CELLS_PER_PAD;
  localparam int SW = NPADS + 5;

  // instruction decode, shared by shift, capture and output paths
  function automatic fbst_path_t path_of(input logic [IR_W-1:0] ins);
    case (ins)
      INS_EXTEST, INS_SAMPLE: path_of = DR_BOUND;
      INS_RING1: path_of = DR_RING1;
      INS_RING2: path_of = DR_RING2;
      INS_CFGW: path_of = DR_CFGW;
      INS_CFGR: path_of = DR_CFGR;
      default: path_of = DR_BYP;
    endcase
  endfunction : path_of

  // tap next-state table
  function automatic fbst_state_t next_of(input fbst_state_t s, input logic m);
    case (s)
      ST_TLR: next_of = m ? ST_TLR : ST_RTI;
      ST_RTI: next_of = m ? ST_SELDR : ST_RTI;
      ST_SELDR: next_of = m ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: next_of = m ? ST_EX1DR : ST_SHDR;
      ST_SHDR: next_of = m ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: next_of = m ? ST_UPDR : ST_PAUDR;
      ST_PAUDR: next_of = m ? ST_EX2DR : ST_PAUDR;
      ST_EX2DR: next_of = m ? ST_UPDR : ST_SHDR;
      ST_UPDR: next_of = m ? ST_SELDR : ST_RTI;
      ST_SELIR: next_of = m ? ST_TLR : ST_CAPIR;
      ST_CAPIR: next_of = m ? ST_EX1IR : ST_SHIR;
      ST_SHIR: next_of = m ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: next_of = m ? ST_UPIR : ST_PAUIR;
      ST_PAUIR: next_of = m ? ST_EX2IR : ST_PAUIR;
      ST_EX2IR: next_of = m ? ST_UPIR : ST_SHIR;
      ST_UPIR: next_of = m ? ST_SELDR : ST_RTI;
      default: next_of = ST_TLR;
    endcase
  endfunction : next_of

  logic [SW-1:0] sync_q;
  logic [NPADS-1:0] pad_s;
  logic tck_s, tms_s, tdi_s, por_s, reconfigure_pin_n_s;
  logic tck_d_r;
  logic tck_rise, tck_fall;
  fbst_state_t state_r;
  logic [IR_W-1:0] ir_sh_r, ir_r;
  logic [NB-1:0] chain_r, upd_r;
  logic byp_r, cfgw_last_r, rb_used_r;
  logic trst, active, extest, rb_ok;
  fbst_path_t path;
  logic dr_so;

  // every pin from the board passes two flops first
  fbst_sync #(
    .W(SW)
  ) u_sync (
    .clock(clock),
    .rstn(rstn),
    .d({pad_in, tck_pin, tms_pin, tdi_pin, powerup_reset_in, reconfigure_pin_n}),
    .q(sync_q)
  );

  assign pad_s = sync_q[SW-1:5];
  assign tck_s = sync_q[4];
  assign tms_s = sync_q[3];
  assign tdi_s = sync_q[2];
  assign por_s = sync_q[1];
  assign reconfigure_pin_n_s = sync_q[0];

  // scan stays alive until configuration ends, then by option
  assign active = !config_done || scan_keep;
  assign trst = por_s || !reconfigure_pin_n_s || !active;
  assign tck_rise = tck_s && !tck_d_r;
  assign tck_fall = !tck_s && tck_d_r;
  assign path = path_of(ir_r);
  assign extest = (ir_r == INS_EXTEST);
  assign rb_ok = config_done && ((readback_option == RB_UNLIMITED) ||
                 ((readback_option == RB_ONE) && !rb_used_r));

  // test clock edge detector
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= tck_s;
    end
  end

  // tap controller steps only on rising test clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_TLR;
    end else if (trst) begin
      state_r <= ST_TLR;
    end else if (tck_rise) begin
      state_r <= next_of(state_r, tms_s);
    end
  end

  // instruction register: capture and shift on rising edge, update on falling edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ir_sh_r <= INS_BYPASS;
      ir_r <= INS_BYPASS;
    end else if (trst || state_r == ST_TLR) begin
      ir_sh_r <= INS_BYPASS;
      ir_r <= INS_BYPASS;
    end else begin
      if (tck_rise && state_r == ST_CAPIR) begin
        ir_sh_r <= IR_CAPTURE;
      end else if (tck_rise && state_r == ST_SHIR) begin
        ir_sh_r <= {tdi_s, ir_sh_r[IR_W-1:1]};
      end
      if (tck_fall && state_r == ST_UPIR) begin
        ir_r <= ir_sh_r;
      end
    end
  end

  // boundary chain: bit 2i is pad i data, 2i+1 its enable; pad 0 next to data in
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      chain_r <= '0;
    end else if (tck_rise && path == DR_BOUND) begin
      if (state_r == ST_CAPDR) begin
        for (int i = 0; i < NPADS; i++) begin
          chain_r[i*CELLS_PER_PAD+CELL_CTRL] <= pad_oe[i];
          chain_r[i*CELLS_PER_PAD+CELL_DATA] <= pad_oe[i] ? pad_out[i] : pad_s[i];
        end
      end else if (state_r == ST_SHDR) begin
        chain_r <= {chain_r[NB-2:0], tdi_s};
      end
    end
  end

  // update stage loads on the falling edge of update-dr
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      upd_r <= '0;
    end else if (trst || state_r == ST_TLR) begin
      upd_r <= '0;
    end else if (tck_fall && state_r == ST_UPDR && path == DR_BOUND) begin
      upd_r <= chain_r;
    end
  end

  // pad drivers: scan values under extest, functional data otherwise
  generate
    for (genvar g = 0; g < NPADS; g++) begin : g_pad
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          pad_out[g] <= 1'b0;
          pad_oe[g] <= 1'b0;
          core_in[g] <= 1'b0;
        end else begin
          pad_out[g] <= extest ? upd_r[g*CELLS_PER_PAD+CELL_DATA] : core_out[g];
          pad_oe[g] <= extest ? upd_r[g*CELLS_PER_PAD+CELL_CTRL] : core_oe[g];
          core_in[g] <= pad_s[g];
        end
      end
    end
  endgenerate

  // single-stage bypass register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      byp_r <= 1'b0;
    end else if (tck_rise && path == DR_BYP) begin
      if (state_r == ST_CAPDR) begin
        byp_r <= 1'b0;
      end else if (state_r == ST_SHDR) begin
        byp_r <= tdi_s;
      end
    end
  end

  // configuration write: each shifted bit goes out with a one-cycle strobe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_wr_bit <= 1'b0;
      cfg_wr_stb <= 1'b0;
      cfgw_last_r <= 1'b0;
    end else begin
      cfg_wr_stb <= 1'b0;
      if (tck_rise && state_r == ST_SHDR && path == DR_CFGW) begin
        cfg_wr_bit <= tdi_s;
        cfg_wr_stb <= 1'b1;
        cfgw_last_r <= tdi_s;
      end
    end
  end

  // configuration read: advance memory per shifted bit, flag that a session has been used
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_rd_next <= 1'b0;
      rb_used_r <= 1'b0;
    end else begin
      cfg_rd_next <= tck_rise && state_r == ST_SHDR && path == DR_CFGR && rb_ok;
      if (tck_fall && state_r == ST_UPDR && path == DR_CFGR && rb_ok) begin
        rb_used_r <= 1'b1;
      end
    end
  end

  // user scan rings see strobes and data from the tap
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ring_si <= 1'b0;
      ring1_sel <= 1'b0;
      ring2_sel <= 1'b0;
      ring_capture <= 1'b0;
      ring_shift <= 1'b0;
      ring_update <= 1'b0;
    end else begin
      ring_si <= tdi_s;
      ring1_sel <= (path == DR_RING1);
      ring2_sel <= (path == DR_RING2);
      ring_capture <= tck_rise && state_r == ST_CAPDR && (path == DR_RING1 || path == DR_RING2);
      ring_shift <= tck_rise && state_r == ST_SHDR && (path == DR_RING1 || path == DR_RING2);
      ring_update <= tck_fall && state_r == ST_UPDR && (path == DR_RING1 || path == DR_RING2);
    end
  end

  // serial output of the selected data register
  always_comb begin
    case (path)
      DR_BOUND: dr_so = chain_r[NB-1];
      DR_RING1: dr_so = ring1_so;
      DR_RING2: dr_so = ring2_so;
      DR_CFGW: dr_so = cfgw_last_r;
      DR_CFGR: dr_so = rb_ok ? cfg_rd_bit : 1'b0;
      default: dr_so = byp_r;
    endcase
  end

  // shared data-out pad: scan bits on falling edge, readback when scan is off
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tdo_out <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (!active) begin
      tdo_out <= rd_data_in;
      tdo_oe <= rd_data_oe_in;
    end else if (tck_fall) begin
      tdo_oe <= (state_r == ST_SHDR) || (state_r == ST_SHIR);
      tdo_out <= (state_r == ST_SHIR) ? ir_sh_r[0] : dr_so;
    end
  end

  // test pins handed to user logic when scan is off
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      user_pins <= '0;
      scan_active <= 1'b0;
    end else begin
      user_pins <= active ? 3'h0 : {tck_s, tms_s, tdi_s};
      scan_active <= active;
    end
  end

  // controller status outputs decoded from the state
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      test_reset <= 1'b1;
      sel_ir <= 1'b0;
      tdo_enable <= 1'b0;
      capture_dr <= 1'b0;
      capture_ir <= 1'b0;
      shift_dr <= 1'b0;
      shift_ir <= 1'b0;
      update_dr <= 1'b0;
      update_ir <= 1'b0;
    end else begin
      test_reset <= (state_r == ST_TLR);
      sel_ir <= (state_r >= ST_SELIR);
      tdo_enable <= (state_r == ST_SHDR) || (state_r == ST_SHIR);
      capture_dr <= (state_r == ST_CAPDR);
      capture_ir <= (state_r == ST_CAPIR);
      shift_dr <= (state_r == ST_SHDR);
      shift_ir <= (state_r == ST_SHIR);
      update_dr <= (state_r == ST_UPDR);
      update_ir <= (state_r == ST_UPIR);
    end
  end

  // no identification register exists; unknown codes fall to bypass
endmodule : fbst_tap

//--- src/fbst_pkg.sv
// constants, encodings and types for the boundary-scan test port
package fbst_pkg;
  // tap controller states
  typedef enum logic [3:0] {
    ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SELDR = 4'h2, ST_CAPDR = 4'h3,
    ST_SHDR = 4'h4, ST_EX1DR = 4'h5, ST_PAUDR = 4'h6, ST_EX2DR = 4'h7,
    ST_UPDR = 4'h8, ST_SELIR = 4'h9, ST_CAPIR = 4'hA, ST_SHIR = 4'hB,
    ST_EX1IR = 4'hC, ST_PAUIR = 4'hD, ST_EX2IR = 4'hE, ST_UPIR = 4'hF
  } fbst_state_t;
  // data register paths chosen by the instruction
  typedef enum logic [2:0] {
    DR_BOUND = 3'h0, DR_RING1 = 3'h1, DR_RING2 = 3'h2,
    DR_CFGW = 3'h3, DR_CFGR = 3'h4, DR_BYP = 3'h5
  } fbst_path_t;
  // instruction codes
  localparam int IR_W = 3;
  localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] INS_RING1 = 3'h1;
  localparam logic [IR_W-1:0] INS_CFGW = 3'h2;
  localparam logic [IR_W-1:0] INS_RSVD = 3'h3;
  localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] INS_RING2 = 3'h5;
  localparam logic [IR_W-1:0] INS_CFGR = 3'h6;
  localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1; // fixed pattern loaded on capture
  // readback limit option
  localparam logic [1:0] RB_INHIBIT = 2'h0;
  localparam logic [1:0] RB_ONE = 2'h1;
  localparam logic [1:0] RB_UNLIMITED = 2'h2;
  // boundary cells per pad and their position within a pad
  localparam int CELLS_PER_PAD = 2;
  localparam int CELL_DATA = 0;
  localparam int CELL_CTRL = 1;
  // default pad count and synchroniser depth
  localparam int NPADS_DEF = 8;
  localparam int SYNC_STAGES = 2;
  // link timing (test clock at most 10 MHz)
  localparam int TCK_MAX_MHZ = 10;
endpackage : fbst_pkg

//--- src/fbst_sync.sv
// two-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps
module fbst_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import fbst_pkg::*;
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : fbst_sync

//--- verif/fbst_tap_chk.sv
// concurrent checks on the ports of the boundary-scan test port
`timescale 1ns/1ps
module fbst_tap_chk #(
  parameter int NPADS = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic tck_pin,
  input wire logic powerup_reset_in,
  input wire logic reconfigure_pin_n,
  input wire logic config_done,
  input wire logic scan_keep,
  input wire logic [NPADS-1:0] pad_in,
  input wire logic [NPADS-1:0] pad_out,
  input wire logic [NPADS-1:0] pad_oe,
  input wire logic [NPADS-1:0] core_out,
  input wire logic [NPADS-1:0] core_oe,
  input wire logic [NPADS-1:0] core_in,
  input wire logic [2:0] user_pins,
  input wire logic ring1_sel,
  input wire logic ring2_sel,
  input wire logic test_reset,
  input wire logic sel_ir,
  input wire logic capture_dr,
  input wire logic capture_ir,
  input wire logic shift_dr,
  input wire logic shift_ir,
  input wire logic update_dr,
  input wire logic update_ir,
  input wire logic scan_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // reset sources and the reset state
  chk_pur_resets_tap: assert property (powerup_reset_in [*6] |-> test_reset)
    else $error("power-up reset did not reset the controller");
  chk_reconf_resets_tap: assert property (!reconfigure_pin_n [*6] |-> test_reset)
    else $error("reconfiguration pin did not reset the controller");
  chk_tlr_frees_pads: assert property (test_reset [*4] |->
    pad_out == $past(core_out) && pad_oe == $past(core_oe))
    else $error("pads not functional in test reset");
  // controller state outputs
  chk_one_state_out: assert property ($onehot0({test_reset, capture_dr, capture_ir,
    shift_dr, shift_ir, update_dr, update_ir}))
    else $error("two controller state outputs at once");
  chk_shift_side: assert property ((shift_ir || shift_dr) |-> sel_ir == shift_ir)
    else $error("register select wrong while shifting");
  chk_tck_steps: assert property (($stable({tck_pin, powerup_reset_in,
    reconfigure_pin_n, config_done, scan_keep})) [*6] |-> $stable({test_reset, capture_dr,
    capture_ir, shift_dr, shift_ir, update_dr, update_ir}))
    else $error("controller moved without a test clock edge");
  // scan enable and pin sharing
  chk_user_pins_quiet: assert property (scan_active [*2] |-> user_pins == 3'h0)
    else $error("user pins active while scan active");
  chk_scan_off_cfg: assert property ((config_done && !scan_keep) [*4] |-> !scan_active)
    else $error("scan still active after configuration");
  chk_scan_on_cfg: assert property ((!config_done && !powerup_reset_in
    && reconfigure_pin_n) [*4] |-> scan_active)
    else $error("scan inactive before configuration");
  chk_core_in_follows: assert property (($stable(pad_in)) [*5] |-> core_in == pad_in)
    else $error("core input disturbed");
  chk_rings_apart: assert property (!(ring1_sel && ring2_sel))
    else $error("both user chains selected");
  cover property (update_ir);
  cover property (shift_dr ##1 !shift_dr);
  cover property (ring1_sel);
  cover property (!scan_active);
endmodule : fbst_tap_chk

//--- verif/fbst_host.sv
// behavioural board test host driving the four test pins
`timescale 1ns/1ps
module fbst_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // test clock stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // new mode and data after the fall, data out taken at the rise
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #62.5;
    o = tdo;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
  endtask : tick
  // five ones reach test reset from any state, then idle
  task automatic tlr();
    logic o;
    repeat (5) tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
  endtask : tlr
  // one instruction or data scan from idle back to idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    dout = '0;
    tick(1'b1, 1'b0, o);
    if (ir) tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
    tick(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, 1'b0, o);
    tick(1'b0, din[0], o);
  endtask : scan
endmodule : fbst_host

//--- verif/fbst_tb.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module testbench;
  import fbst_pkg::*;
  localparam int N = 8;
  localparam int NB = 2 * N;
  // stimulus toward the design
  logic clock = 1'b0, rstn = 1'b0, powerup_reset_in = 1'b0, reconfigure_pin_n = 1'b1;
  logic config_done = 1'b0, scan_keep = 1'b0, rd_data_in = 1'b0, rd_data_oe_in = 1'b0;
  logic ring1_so = 1'b0, ring2_so = 1'b0, cfg_rd_bit = 1'b1;
  logic [1:0] readback_option = RB_UNLIMITED;
  logic [N-1:0] pad_in = '0, core_out = '0, core_oe = '0;
  // design outputs, and the test pins driven by the host
  logic tck_pin, tms_pin, tdi_pin, tdo_out, tdo_oe, ring_si, ring1_sel, ring2_sel, ring_shift;
  logic ring_capture, ring_update, cfg_wr_bit, cfg_wr_stb, cfg_rd_next, test_reset, sel_ir;
  logic tdo_enable, capture_dr, capture_ir, shift_dr, shift_ir, update_dr, update_ir;
  logic scan_active;
  logic [N-1:0] pad_out, pad_oe, core_in;
  logic [2:0] user_pins;
  int mismatches = 0, compares = 0, n_shift = 0, n_wr = 0, n_edge = 0, n_rd = 0;
  int b_shift, b_wr, b_edge, b_rd;
  integer seed = 32'h68fd8409;
  logic [31:0] wr_bits, din, dout, p;
  always #4 clock = ~clock;
  fbst_tap #(.NPADS(N)) i_dut (.clock, .rstn, .tck_pin, .tms_pin, .tdi_pin, .tdo_out, .tdo_oe,
    .powerup_reset_in, .reconfigure_pin_n, .config_done, .scan_keep, .readback_option,
    .rd_data_in, .rd_data_oe_in, .pad_in, .pad_out, .pad_oe, .core_out, .core_oe, .core_in,
    .user_pins, .ring1_so, .ring2_so, .ring_si, .ring1_sel, .ring2_sel, .ring_capture,
    .ring_shift, .ring_update, .cfg_wr_bit, .cfg_wr_stb, .cfg_rd_bit, .cfg_rd_next,
    .test_reset, .sel_ir, .tdo_enable, .capture_dr, .capture_ir, .shift_dr, .shift_ir,
    .update_dr, .update_ir, .scan_active);
  fbst_host i_host (.tck(tck_pin), .tms(tms_pin), .tdi(tdi_pin), .tdo(tdo_out));
  // count strobes; written configuration bits enter at the top
  always @(posedge clock) begin
    if (ring_shift) n_shift++;
    if (ring_capture || ring_update) n_edge++;
    if (cfg_rd_next) n_rd++;
    if (cfg_wr_stb) begin
      wr_bits = {cfg_wr_bit, wr_bits[31:1]};
      n_wr++;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // reset, wait for scan to come up, then park the controller in idle
  task automatic do_reset();
    int k;
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    for (k = 0; k < 50 && scan_active !== 1'b1; k++) @(posedge clock);
    if (k == 50) begin
      mismatches++;
      results();
    end
    i_host.tlr();
  endtask : do_reset
  // expected boundary capture: data is the driven value when enabled, else the pad
  function automatic logic [31:0] exp_cap(input logic [N-1:0] po, oe, pi);
    logic [31:0] c;
    c = '0;
    for (int i = 0; i < N; i++) begin
      c[2*i] = oe[i] ? po[i] : pi[i];
      c[2*i+1] = oe[i];
    end
    return c;
  endfunction : exp_cap
  // the first bit out is the far end of the chain
  function automatic logic [31:0] rev(input logic [31:0] x);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < NB; i++) r[i] = x[NB-1-i];
    return r;
  endfunction : rev
  // chain to {enables, data} as the pads should show it
  function automatic logic [31:0] pads_of(input logic [31:0] ch);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < N; i++) begin
      r[i] = ch[2*i];
      r[N+i] = ch[2*i+1];
    end
    return r;
  endfunction : pads_of
  initial begin
    logic [2:0] codes [5] = '{INS_BYPASS, INS_RSVD, INS_RING1, INS_RING2, INS_CFGW};
    logic [1:0] rbo [3] = '{RB_INHIBIT, RB_ONE, RB_UNLIMITED};
    do_reset();
    // capture pattern and single-stage bypass for both bypass codes
    for (int k = 0; k < 2; k++) begin
      i_host.scan(1'b1, 3, {29'h0, codes[k]}, dout);
      check("ir capture", dout, {29'h0, IR_CAPTURE});
      din = $random(seed);
      i_host.scan(1'b0, 8, din, dout);
      check("bypass out", dout, {24'h0, din[6:0], 1'b0});
    end
    $display("test bypass done");
    // sample keeps pads functional; preload then extest drives them
    @(posedge clock);
    core_out <= N'($random(seed));
    core_oe <= N'($random(seed));
    pad_in <= N'($random(seed));
    i_host.scan(1'b1, 3, {29'h0, INS_SAMPLE}, dout);
    for (int k = 0; k < 2; k++) begin
      p = pads_of(rev(din));
      din = $random(seed);
      i_host.scan(1'b0, NB, din, dout);
      if (k == 0) check("sample cap", dout, rev(exp_cap(core_out, core_oe, pad_in)));
      else check("extest cap", dout, rev(exp_cap(p[N-1:0], p[NB-1:N], pad_in)));
      if (k == 0) check("sample pads", 32'({pad_oe, pad_out}), 32'({core_oe, core_out}));
      if (k == 0) i_host.scan(1'b1, 3, {29'h0, INS_EXTEST}, dout);
      repeat (8) @(posedge clock);
      check("extest pads", 32'({pad_oe, pad_out}), pads_of(rev(din)));
    end
    // either reset source frees the pads and restores bypass
    for (int k = 0; k < 2; k++) begin
      i_host.scan(1'b1, 3, {29'h0, INS_EXTEST}, dout);
      @(posedge clock);
      if (k == 0) reconfigure_pin_n <= 1'b0;
      else powerup_reset_in <= 1'b1;
      repeat (8) @(posedge clock);
      check("reset level", 32'(test_reset), 32'h1);
      check("reset pads", 32'({pad_oe, pad_out}), 32'({core_oe, core_out}));
      reconfigure_pin_n <= 1'b1;
      powerup_reset_in <= 1'b0;
      repeat (4) @(posedge clock);
      i_host.tlr();
      din = $random(seed);
      i_host.scan(1'b0, 8, din, dout);
      check("reset bypass", dout, {24'h0, din[6:0], 1'b0});
    end
    $display("test boundary done");
    // user chains and serial configuration write, one strobe per bit
    @(posedge clock);
    ring1_so <= 1'b1;
    for (int k = 2; k < 5; k++) begin
      i_host.scan(1'b1, 3, {29'h0, codes[k]}, dout);
      b_shift = n_shift;
      b_wr = n_wr;
      b_edge = n_edge;
      din = $random(seed);
      i_host.scan(1'b0, 8, din, dout);
      repeat (8) @(posedge clock);
      check("ring1 sel", 32'(ring1_sel), 32'(codes[k] == INS_RING1));
      check("ring2 sel", 32'(ring2_sel), 32'(codes[k] == INS_RING2));
      p = 32'(codes[k] == INS_CFGW);
      check("chain strobes", 32'(n_shift - b_shift), p ? 32'h0 : 32'h8);
      check("chain edges", 32'(n_edge - b_edge), p ? 32'h0 : 32'h2);
      check("cfg strobes", 32'(n_wr - b_wr), p ? 32'h8 : 32'h0);
      check("ring data", 32'(ring_si), 32'(tdi_pin));
      if (codes[k] != INS_CFGW) check("chain out", dout, k == 2 ? 32'hFF : 32'h0);
      else check("cfg bits", wr_bits >> 24, din & 32'hFF);
    end
    $display("test chains done");
    // readback limited by option: none, one, unlimited
    config_done <= 1'b1;
    scan_keep <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(posedge clock);
      readback_option <= rbo[k];
      do_reset();
      i_host.scan(1'b1, 3, {29'h0, INS_CFGR}, dout);
      for (int j = 0; j < 2; j++) begin
        b_rd = n_rd;
        i_host.scan(1'b0, 8, 32'h0, dout);
        p = ((j == 0) ? k != 0 : k == 2) ? 32'hFF : 32'h0;
        check("readback", dout, p);
        check("readback steps", 32'(n_rd - b_rd), p == 0 ? 32'h0 : 32'h8);
      end
    end
    $display("test readback done");
    // scan disabled: test pins become user pins, readback owns the data-out pad
    @(posedge clock);
    scan_keep <= 1'b0;
    rd_data_in <= 1'b1;
    rd_data_oe_in <= 1'b1;
    repeat (8) @(posedge clock);
    check("scan off", 32'(scan_active), 32'h0);
    check("user pins", 32'(user_pins), 32'({tck_pin, tms_pin, tdi_pin}));
    check("pad readback", 32'({tdo_oe, tdo_out}), 32'h3);
    $display("test disable done");
    results();
  end
endmodule : testbench
bind fbst_tap fbst_tap_chk #(.NPADS(NPADS)) i_chk (.clock, .rstn, .tck_pin, .powerup_reset_in,
  .reconfigure_pin_n, .config_done, .scan_keep, .pad_in, .pad_out, .pad_oe, .core_out, .core_oe,
  .core_in, .user_pins, .ring1_sel, .ring2_sel, .test_reset, .sel_ir, .capture_dr, .capture_ir,
  .shift_dr, .shift_ir, .update_dr, .update_ir, .scan_active);
